// ==== common/tocu_pkg.sv ====
// Package for the 8-bit timer output compare unit: register offsets, field layouts, reset values, modes.
// Assumes a single 50 MHz clock domain and a plain strobe register port.
package tocu_pkg;
  localparam logic [2:0] TOCU_ADDR_CTRL = 3'h0;
  localparam logic [2:0] TOCU_ADDR_COUNT = 3'h1;
  localparam logic [2:0] TOCU_ADDR_COMPARE = 3'h2;
  localparam logic [2:0] TOCU_ADDR_FLAGS = 3'h3;
  localparam logic [2:0] TOCU_ADDR_MASK = 3'h4;
  localparam logic [2:0] TOCU_ADDR_PORT = 3'h5;
  localparam logic [2:0] TOCU_ADDR_ACK = 3'h6;
  localparam int TOCU_CTRL_WGM_LSB = 0;
  localparam int TOCU_CTRL_COM_LSB = 2;
  localparam int TOCU_CTRL_FORCE_BIT = 4;
  localparam int TOCU_CTRL_RUN_BIT = 5;
  localparam int TOCU_FLAG_OVF_BIT = 0;
  localparam int TOCU_FLAG_CMP_BIT = 1;
  localparam int TOCU_PORT_VAL_BIT = 0;
  localparam int TOCU_PORT_DIR_BIT = 1;
  localparam logic [7:0] TOCU_RST_BYTE = 8'h00;
  localparam logic [7:0] TOCU_MAX = 8'hFF;
  localparam logic [7:0] TOCU_BOTTOM = 8'h00;

  typedef enum logic [1:0] {
    TOCU_WGM_NORMAL = 2'b00,
    TOCU_WGM_PC_PWM = 2'b01,
    TOCU_WGM_CTC = 2'b10,
    TOCU_WGM_FAST_PWM = 2'b11
  } tocu_wgm_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tocu_bus_t;
endpackage

// ==== verilog/tocu_timer.sv ====
// Timer/counter with one output compare channel, normal/CLEAR_ON_MATCH_MODE/PWM counting and pin override.
// Assumes the register port master obeys one-cycle strobes; the timer ticks whenever the run bit is set.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Compare count with compare value continuously.
// - Match sets compare flag one cycle later.
// - Enabled flag requests interrupt; cleared when serviced.
// - Writing one clears compare flag.
// - Compare value buffered only in PWM modes.
// - Buffered value loads at top in both PWM modes.
// - CPU writes buffer or active register by mode.
// - Force strobe makes match in non-PWM modes.
// - Forced match updates output only, no flag.
// - Count write blocks matches next cycle.
// - Output action bits apply from next match.
// - Output state kept across mode changes.
// - Nonzero action bits override port output value.
// - Output visible only when direction is output.
// - Action zero leaves output state untouched.
// - Action bits never change counting sequence.
// - Action bits: PWM polarity or set/clear/toggle.
// - Normal mode increments and wraps FF to 00.
// - Overflow flag set as count becomes zero.
// - Count may be written any time.
// - Mode 2 clears counter on compare match.
// - Mode 3 fast PWM, mode 1 phase correct.
// - CPU count write beats clear or count.
module tocu_timer (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire tocu_pkg::tocu_bus_t i_bus,
  output logic [7:0] o_rdata,
  output logic o_irq_compare,
  output logic o_irq_overflow,
  output logic o_pin_out,
  output logic o_pin_oe
);
  import tocu_pkg::*;

  logic [7:0] timer_count_value;
  logic [7:0] compare_value_register;
  logic [7:0] compare_buffer;
  logic [1:0] waveform_mode_select;
  logic [1:0] compare_output_action;
  logic timer_run;
  logic compare_match_flag;
  logic overflow_flag;
  logic compare_interrupt_enable;
  logic overflow_interrupt_enable;
  logic compare_output_state;
  logic port_value;
  logic output_pin_direction_bit;
  logic count_down;
  logic match_blocked;
  logic [7:0] next_count;
  logic next_down;
  logic next_state;
  logic raw_match;
  logic match;
  logic pwm_mode;
  logic tick;
  logic wr_count;
  logic force_hit;
  logic at_top;

  function automatic logic is_wr(input tocu_bus_t b, input logic [2:0] a);
    return b.wr && (b.addr == a);
  endfunction

  assign pwm_mode = waveform_mode_select[0];
  assign tick = timer_run;
  assign wr_count = is_wr(i_bus, TOCU_ADDR_COUNT);
  // The comparator looks at the count at all times; matches are masked for one cycle after a count write.
  assign raw_match = (timer_count_value == compare_value_register);
  assign match = raw_match && !match_blocked && tick;
  // Force only in non-PWM modes; the strobe is never stored so it reads back as zero.
  assign force_hit = is_wr(i_bus, TOCU_ADDR_CTRL) && i_bus.wdata[TOCU_CTRL_FORCE_BIT] && !pwm_mode;
  assign at_top = (timer_count_value == TOCU_MAX);

  // Counting depends only on the mode bits, never on the action bits.
  always_comb begin
    next_count = timer_count_value;
    next_down = count_down;
    case (tocu_wgm_t'(waveform_mode_select))
      TOCU_WGM_NORMAL: next_count = timer_count_value + 8'h01;
      TOCU_WGM_CTC: next_count = raw_match ? TOCU_BOTTOM : timer_count_value + 8'h01;
      TOCU_WGM_FAST_PWM: next_count = timer_count_value + 8'h01;
      TOCU_WGM_PC_PWM: begin
        if (at_top) begin
          next_down = 1'b1;
        end else if (timer_count_value == TOCU_BOTTOM) begin
          next_down = 1'b0;
        end
        next_count = (at_top || (count_down && timer_count_value != TOCU_BOTTOM))
          ? timer_count_value - 8'h01 : timer_count_value + 8'h01;
      end
      default: next_count = timer_count_value;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      timer_count_value <= TOCU_RST_BYTE;
      count_down <= 1'b0;
    end else if (wr_count) begin
      timer_count_value <= i_bus.wdata;
    end else if (tick) begin
      timer_count_value <= next_count;
      count_down <= next_down;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      match_blocked <= 1'b0;
    end else begin
      match_blocked <= wr_count;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      waveform_mode_select <= 2'h0;
      compare_output_action <= 2'h0;
      timer_run <= 1'b0;
      compare_interrupt_enable <= 1'b0;
      overflow_interrupt_enable <= 1'b0;
      port_value <= 1'b0;
      output_pin_direction_bit <= 1'b0;
    end else begin
      if (is_wr(i_bus, TOCU_ADDR_CTRL)) begin
        waveform_mode_select <= i_bus.wdata[TOCU_CTRL_WGM_LSB +: 2];
        compare_output_action <= i_bus.wdata[TOCU_CTRL_COM_LSB +: 2];
        timer_run <= i_bus.wdata[TOCU_CTRL_RUN_BIT];
      end
      if (is_wr(i_bus, TOCU_ADDR_MASK)) begin
        overflow_interrupt_enable <= i_bus.wdata[TOCU_FLAG_OVF_BIT];
        compare_interrupt_enable <= i_bus.wdata[TOCU_FLAG_CMP_BIT];
      end
      if (is_wr(i_bus, TOCU_ADDR_PORT)) begin
        port_value <= i_bus.wdata[TOCU_PORT_VAL_BIT];
        output_pin_direction_bit <= i_bus.wdata[TOCU_PORT_DIR_BIT];
      end
    end
  end

  // Buffered updates keep PWM pulses whole; CLEAR_ON_MATCH_MODE has no buffer so a low new top can miss a match.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      compare_value_register <= TOCU_RST_BYTE;
      compare_buffer <= TOCU_RST_BYTE;
    end else begin
      if (is_wr(i_bus, TOCU_ADDR_COMPARE)) begin
        compare_buffer <= i_bus.wdata;
      end
      if (!pwm_mode && is_wr(i_bus, TOCU_ADDR_COMPARE)) begin
        compare_value_register <= i_bus.wdata;
      end else if (pwm_mode && tick && !wr_count) begin
        if ((waveform_mode_select == TOCU_WGM_FAST_PWM && at_top) ||
            (waveform_mode_select == TOCU_WGM_PC_PWM && at_top)) begin
          compare_value_register <= compare_buffer;
        end
      end
    end
  end

  always_comb begin
    next_state = compare_output_state;
    if (match || force_hit) begin
      if (!pwm_mode) begin
        case (compare_output_action)
          2'h1: next_state = !compare_output_state;
          2'h2: next_state = 1'b0;
          2'h3: next_state = 1'b1;
          default: next_state = compare_output_state;
        endcase
      end else if (compare_output_action[1]) begin
        if (waveform_mode_select == TOCU_WGM_FAST_PWM) begin
          next_state = compare_output_action[0];
        end else begin
          next_state = compare_output_action[0] ^ count_down;
        end
      end else if (compare_output_action == 2'h1 && waveform_mode_select == TOCU_WGM_FAST_PWM) begin
        next_state = !compare_output_state;
      end
    end else if (tick && !wr_count && waveform_mode_select == TOCU_WGM_FAST_PWM &&
                 at_top && compare_output_action[1]) begin
      next_state = !compare_output_action[0];
    end
  end

  // Mode writes never touch this register, so its value survives mode changes.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      compare_output_state <= 1'b0;
    end else begin
      compare_output_state <= next_state;
    end
  end

  // Set wins over a simultaneous software or service clear.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      compare_match_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      if (match) begin
        compare_match_flag <= 1'b1;
      end else if ((is_wr(i_bus, TOCU_ADDR_FLAGS) && i_bus.wdata[TOCU_FLAG_CMP_BIT]) ||
                   (is_wr(i_bus, TOCU_ADDR_ACK) && i_bus.wdata[TOCU_FLAG_CMP_BIT])) begin
        compare_match_flag <= 1'b0;
      end
      if (tick && !wr_count && next_count == TOCU_BOTTOM && timer_count_value != TOCU_BOTTOM) begin
        overflow_flag <= 1'b1;
      end else if (is_wr(i_bus, TOCU_ADDR_FLAGS) || is_wr(i_bus, TOCU_ADDR_ACK)) begin
        if (i_bus.wdata[TOCU_FLAG_OVF_BIT]) begin
          overflow_flag <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq_compare <= 1'b0;
      o_irq_overflow <= 1'b0;
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
    end else begin
      o_irq_compare <= compare_match_flag && compare_interrupt_enable;
      o_irq_overflow <= overflow_flag && overflow_interrupt_enable;
      o_pin_out <= (compare_output_action != 2'h0) ? compare_output_state : port_value;
      o_pin_oe <= output_pin_direction_bit;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= TOCU_RST_BYTE;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        TOCU_ADDR_CTRL: o_rdata <= {2'h0, timer_run, 1'b0, compare_output_action, waveform_mode_select};
        TOCU_ADDR_COUNT: o_rdata <= timer_count_value;
        TOCU_ADDR_COMPARE: o_rdata <= pwm_mode ? compare_buffer : compare_value_register;
        TOCU_ADDR_FLAGS: o_rdata <= {6'h00, compare_match_flag, overflow_flag};
        TOCU_ADDR_MASK: o_rdata <= {6'h00, compare_interrupt_enable, overflow_interrupt_enable};
        TOCU_ADDR_PORT: o_rdata <= {5'h00, compare_output_state, output_pin_direction_bit, port_value};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  property p_flag_after_match;
    @(posedge i_clock) disable iff (i_sys_rst) match |=> compare_match_flag;
  endproperty
  a_flag_after_match: assert property (p_flag_after_match) else $error("Compare flag not set after match.");

  property p_block_after_write;
    @(posedge i_clock) disable iff (i_sys_rst) wr_count |=> !match;
  endproperty
  a_block_after_write: assert property (p_block_after_write) else $error("Match not blocked after count write.");

  property p_force_no_flag;
    @(posedge i_clock) disable iff (i_sys_rst)
      (force_hit && !match && !compare_match_flag) |=> !compare_match_flag;
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("Forced match set the flag.");

  property p_pin_override;
    @(posedge i_clock) disable iff (i_sys_rst)
      (compare_output_action != 2'h0) |=> (o_pin_out == $past(compare_output_state));
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("Pin not driven by output state.");

  property p_com_zero_hold;
    @(posedge i_clock) disable iff (i_sys_rst)
      (compare_output_action == 2'h0) |=> $stable(compare_output_state);
  endproperty
  a_com_zero_hold: assert property (p_com_zero_hold) else $error("Output state changed with action zero.");

  property p_normal_wrap;
    @(posedge i_clock) disable iff (i_sys_rst)
      (tick && !wr_count && waveform_mode_select == 2'h0 && at_top) |=> (timer_count_value == 8'h00 && overflow_flag);
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("Normal mode wrap or overflow wrong.");

  property p_ctc_clear;
    @(posedge i_clock) disable iff (i_sys_rst)
      (tick && !wr_count && waveform_mode_select == 2'h2 && raw_match) |=> timer_count_value == 8'h00;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("Clear-on-match did not clear.");

  property p_write_priority;
    @(posedge i_clock) disable iff (i_sys_rst) wr_count |=> timer_count_value == $past(i_bus.wdata);
  endproperty
  a_write_priority: assert property (p_write_priority) else $error("Count write lost.");

  property p_direct_compare;
    @(posedge i_clock) disable iff (i_sys_rst)
      (!pwm_mode && is_wr(i_bus, TOCU_ADDR_COMPARE)) |=> compare_value_register == $past(i_bus.wdata);
  endproperty
  a_direct_compare: assert property (p_direct_compare) else $error("Unbuffered compare write missed.");
endmodule

`default_nettype wire

// ==== sim/tocu_tb.sv ====
// Self-checking bench for the timer output compare unit, driving its register port directly.
// Assumes the single-clock design with registered read data one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tocu_pkg::*;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  tocu_bus_t bus = '0;
  logic [7:0] o_rdata;
  logic o_irq_compare;
  logic o_irq_overflow;
  logic o_pin_out;
  logic o_pin_oe;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] v;

  always #10 i_clock = ~i_clock;

  tocu_timer tocu_timer_inst (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_bus(bus),
    .o_rdata(o_rdata),
    .o_irq_compare(o_irq_compare),
    .o_irq_overflow(o_irq_overflow),
    .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe)
  );

  task automatic complete_run;
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles, so this ceiling only catches a hang.
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail = n_fail + 1;
      $display("Error run_cycles expected below 4000 seen %0d", cycles);
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask

  // A gap cycle follows every strobe, so a strobe is never assigned twice in one time step.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge i_clock);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clock);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_clock);
    bus.rd <= 1'b0;
    @(posedge i_clock);
    d = o_rdata;
  endtask

  task automatic cw(input logic run, input logic frc, input logic [1:0] act, input tocu_wgm_t mode);
    wr(TOCU_ADDR_CTRL, {2'b00, run, frc, act, mode});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // Action bits are settled in a separate write first, so the strobe never races a field change.
  task automatic force_act(input logic [1:0] act);
    cw(1'b0, 1'b0, act, TOCU_WGM_NORMAL);
    cw(1'b0, 1'b1, act, TOCU_WGM_NORMAL);
  endtask

  task automatic state_is(input logic exp);
    rd(TOCU_ADDR_PORT, v);
    chk1("output_state", exp, v[2]);
  endtask

  task automatic run_stop(input logic [7:0] start, input logic [1:0] act, input tocu_wgm_t mode, input int n);
    wr(TOCU_ADDR_COUNT, start);
    cw(1'b1, 1'b0, act, mode);
    idle(n);
    cw(1'b0, 1'b0, act, mode);
  endtask

  initial begin
    idle(5);
    i_sys_rst <= 1'b0;
    idle(1);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      chk("reset_read", 8'h00, v);
    end
    chk1("pin_oe_reset", 1'b0, o_pin_oe);
    chk1("irq_reset", 1'b0, o_irq_compare | o_irq_overflow);
    force_act(2'd3);
    state_is(1'b1);
    rd(TOCU_ADDR_FLAGS, v);
    chk("flags_after_force", 8'h00, v);
    rd(TOCU_ADDR_COUNT, v);
    chk("count_after_force", 8'h00, v);
    force_act(2'd2);
    state_is(1'b0);
    force_act(2'd1);
    state_is(1'b1);
    force_act(2'd1);
    state_is(1'b0);
    force_act(2'd3);
    force_act(2'd0);
    state_is(1'b1);
    rd(TOCU_ADDR_CTRL, v);
    chk("ctrl_readback", 8'h00, v);
    idle(2);
    chk1("pin_oe_input", 1'b0, o_pin_oe);
    wr(TOCU_ADDR_PORT, 8'h02);
    cw(1'b0, 1'b0, 2'd3, TOCU_WGM_NORMAL);
    idle(2);
    chk1("pin_oe_output", 1'b1, o_pin_oe);
    chk1("pin_override", 1'b1, o_pin_out);
    cw(1'b0, 1'b0, 2'd0, TOCU_WGM_NORMAL);
    idle(2);
    chk1("pin_port_value", 1'b0, o_pin_out);
    cw(1'b0, 1'b0, 2'd2, TOCU_WGM_FAST_PWM);
    cw(1'b0, 1'b1, 2'd2, TOCU_WGM_FAST_PWM);
    state_is(1'b1);
    cw(1'b0, 1'b0, 2'd0, TOCU_WGM_NORMAL);
    wr(TOCU_ADDR_COMPARE, 8'h20);
    rd(TOCU_ADDR_COMPARE, v);
    chk("compare_direct", 8'h20, v);
    cw(1'b0, 1'b0, 2'd0, TOCU_WGM_FAST_PWM);
    wr(TOCU_ADDR_COMPARE, 8'h80);
    rd(TOCU_ADDR_COMPARE, v);
    chk("compare_buffer", 8'h80, v);
    run_stop(8'h1E, 2'd0, TOCU_WGM_FAST_PWM, 6);
    rd(TOCU_ADDR_FLAGS, v);
    chk("flags_buffered_match", 8'h02, v);
    wr(TOCU_ADDR_FLAGS, 8'h02);
    cw(1'b0, 1'b0, 2'd1, TOCU_WGM_NORMAL);
    wr(TOCU_ADDR_COMPARE, 8'h30);
    cw(1'b1, 1'b0, 2'd1, TOCU_WGM_NORMAL);
    wr(TOCU_ADDR_COUNT, 8'h30);
    idle(4);
    cw(1'b0, 1'b0, 2'd1, TOCU_WGM_NORMAL);
    rd(TOCU_ADDR_FLAGS, v);
    chk("flags_blocked", 8'h00, v);
    state_is(1'b1);
    rd(TOCU_ADDR_COUNT, v);
    chk1("count_up_range", 1'b1, v > 8'h30 && v < 8'h3C);
    run_stop(8'h2E, 2'd1, TOCU_WGM_NORMAL, 6);
    rd(TOCU_ADDR_FLAGS, v);
    chk("flags_match", 8'h02, v);
    state_is(1'b0);
    wr(TOCU_ADDR_FLAGS, 8'h00);
    rd(TOCU_ADDR_FLAGS, v);
    chk("flags_write_zero", 8'h02, v);
    wr(TOCU_ADDR_MASK, 8'h02);
    idle(2);
    chk1("irq_compare_on", 1'b1, o_irq_compare);
    wr(TOCU_ADDR_FLAGS, 8'h02);
    idle(2);
    chk1("irq_compare_off", 1'b0, o_irq_compare);
    run_stop(8'hFD, 2'd0, TOCU_WGM_NORMAL, 6);
    rd(TOCU_ADDR_FLAGS, v);
    chk("flags_overflow", 8'h01, v);
    rd(TOCU_ADDR_COUNT, v);
    chk1("count_wrapped", 1'b1, v < 8'h0A);
    wr(TOCU_ADDR_MASK, 8'h01);
    idle(2);
    chk1("irq_overflow_on", 1'b1, o_irq_overflow);
    wr(TOCU_ADDR_ACK, 8'h01);
    idle(2);
    chk1("irq_overflow_off", 1'b0, o_irq_overflow);
    wr(TOCU_ADDR_COMPARE, 8'h05);
    run_stop(8'h02, 2'd0, TOCU_WGM_CTC, 10);
    rd(TOCU_ADDR_COUNT, v);
    chk1("count_clear_on_match", 1'b1, v <= 8'h05);
    run_stop(8'hFD, 2'd0, TOCU_WGM_PC_PWM, 6);
    rd(TOCU_ADDR_COUNT, v);
    chk1("count_dual_slope", 1'b1, v >= 8'hF0);
    run_stop(8'h02, 2'd3, TOCU_WGM_FAST_PWM, 6);
    state_is(1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
